// *** hdl/blit_control_status_regs.sv ***
// Control and status registers of the block-transfer engine with its pixel sequencer.
//
// Function
// [RL1] Registers decoded as group at 8000h.
// [RL2] Colour bit: clear 8 bpp, set 16 bpp.
// [RL3] Counter step size follows colour depth.
// [RL4] Rectangular destination: next row via offset.
// [RL5] Destination linear: rows written back to back.
// [RL6] Rectangular source: next row via offset.
// [RL7] Source linear: rows read back to back.
// [RL8] Enable is write-only; writing one starts.
// [RL9] Software never clears enable while busy.
// [RL10] Busy flag sits in status bit 0.
// [RL11] Used-entries field, zero means empty.
// [RL12] Free-entries field, zero means full.
// [RL13] Not-empty flag bit 6 tracks occupancy.
// [RL14] Half-full flag bit 5 at half.
// [RL15] Full flag bit 4 when full.
// [RL16] Flags encode 0, 1-6, 7-14, 15-16.
// [RL17] Software polls not-empty before burst reads.
// [RL18] Busy high while running, low when done.
// [RL19] Read transfer pauses full, resumes below fourteen.
// [RL20] Unused bits read zero, writes ignored.
`timescale 1ns/1ns
`default_nettype none
module blit_control_status_regs
    import blit_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    input wire blit_job_s job,
    output mem_req_s memReq,
    output logic memValid,
    input wire logic memReady,
    input wire logic hostPush,
    input wire logic hostPop,
    output logic busy,
    output logic colorDepth16
);

    if (DEPTH <= int'(RESUME_LEVEL)) begin : g_resume_check
        $error("FIFO depth must exceed the resume level.");
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Register decode.

    function automatic logic hitReg(input logic [REG_AW-1:0] addr, input logic [REG_AW-1:0] ofs);
        hitReg = (addr == ofs) && (addr[REG_AW-1:12] == BLIT_BASE[REG_AW-1:12]);
    endfunction : hitReg

    logic ctrlWr;
    logic startReq;

    assign ctrlWr = regWr && hitReg(regAddr, CTRL_OFS); // RL1
    assign startReq = ctrlWr && regWdata[CTRL_ENABLE_BIT]; // RL8

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Control register.

    logic srcLinear_r;
    logic dstLinear_r;
    logic color16_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            {color16_r, dstLinear_r, srcLinear_r} <= CTRL_RESET;
        end else if (ce && ctrlWr) begin
            // Only the three mode bits are stored; the remaining bits are dropped.
            srcLinear_r <= regWdata[CTRL_SRC_LIN_BIT]; // RL7 RL20
            dstLinear_r <= regWdata[CTRL_DST_LIN_BIT]; // RL5
            color16_r <= regWdata[CTRL_COLOR_BIT]; // RL2
        end
    end

    assign colorDepth16 = color16_r;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // FIFO occupancy.

    logic [LEVEL_W-1:0] level;
    logic [LEVEL_W-1:0] freeCount;
    logic notEmpty;
    logic halfFull;
    logic fullFlag;
    logic atCapacity;
    logic engPush;
    logic engPop;

    blit_fifo_level #(
        .DEPTH(DEPTH)
    ) u_level (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .push(hostPush || engPush),
        .pop(hostPop || engPop),
        .level(level),
        .freeCount(freeCount),
        .notEmpty(notEmpty),
        .halfFull(halfFull),
        .fullFlag(fullFlag),
        .atCapacity(atCapacity)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    eng_state_e state_r;
    eng_state_e state_nxt;
    blit_job_s job_r;
    logic [CNT_W-1:0] col_r;
    logic [CNT_W-1:0] row_r;
    logic rowEnd;
    logic lastPixel;
    logic pixelDone;
    logic canIssue;
    logic [1:0] step;

    assign step = color16_r ? STEP_16BPP : STEP_8BPP; // RL2 RL3
    assign rowEnd = (col_r == job_r.widthPix - 10'h001);
    assign lastPixel = rowEnd && (row_r == job_r.heightRows - 10'h001);
    // A write transfer needs a word waiting; a read transfer needs room for one.
    assign canIssue = job_r.readOp ? !atCapacity : notEmpty;
    assign memValid = (state_r == ST_RUN) && canIssue;
    assign pixelDone = memValid && memReady;
    assign engPush = pixelDone && job_r.readOp;
    assign engPop = pixelDone && !job_r.readOp;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (startReq) begin
                    state_nxt = ST_RUN; // RL8 RL18
                end
            end
            ST_RUN: begin
                if (pixelDone && lastPixel) begin
                    state_nxt = ST_IDLE; // RL18
                end else if (job_r.readOp && atCapacity) begin
                    state_nxt = ST_PAUSE; // RL19
                end
            end
            ST_PAUSE: begin
                if (level < RESUME_LEVEL) begin
                    state_nxt = ST_RUN; // RL19
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // A start while busy is ignored; the job is captured only when idle.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            job_r <= '0;
        end else if (ce && state_r == ST_IDLE && startReq) begin
            job_r <= job;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            col_r <= '0;
            row_r <= '0;
        end else if (ce) begin
            if (state_r == ST_IDLE && startReq) begin
                col_r <= '0;
                row_r <= '0;
            end else if (pixelDone && rowEnd) begin
                col_r <= '0;
                row_r <= row_r + 10'h001;
            end else if (pixelDone) begin
                col_r <= col_r + 10'h001;
            end
        end
    end

    assign busy = (state_r != ST_IDLE); // RL18

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Source and destination pointers.

    logic loadPtr;
    logic [ADDR_W-1:0] srcAddr;
    logic [ADDR_W-1:0] dstAddr;

    assign loadPtr = (state_r == ST_IDLE) && startReq;

    blit_addr_step u_src (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .load(loadPtr),
        .startAddr(job.srcStart),
        .advance(pixelDone),
        .rowEnd(rowEnd),
        .linear(srcLinear_r), // RL6 RL7
        .step(step), // RL3
        .rowOffset(job_r.rowOffset),
        .addr(srcAddr)
    );

    blit_addr_step u_dst (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .load(loadPtr),
        .startAddr(job.dstStart),
        .advance(pixelDone),
        .rowEnd(rowEnd),
        .linear(dstLinear_r), // RL4 RL5
        .step(step),
        .rowOffset(job_r.rowOffset),
        .addr(dstAddr)
    );

    assign memReq.srcAddr = srcAddr;
    assign memReq.dstAddr = dstAddr;
    assign memReq.toFifo = job_r.readOp;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Read port.

    logic [DATA_W-1:0] ctrlView;
    logic [DATA_W-1:0] statView;
    logic [DATA_W-1:0] regRdata_r;

    always_comb begin
        ctrlView = '0; // RL20
        ctrlView[CTRL_SRC_LIN_BIT] = srcLinear_r;
        ctrlView[CTRL_DST_LIN_BIT] = dstLinear_r;
        ctrlView[CTRL_COLOR_BIT] = color16_r;
    end

    always_comb begin
        statView = STAT_RESET; // RL20
        statView[STAT_BUSY_BIT] = busy; // RL10
        statView[STAT_FULL_BIT] = fullFlag; // RL15 RL16
        statView[STAT_HALF_BIT] = halfFull; // RL14 RL16
        statView[STAT_NEMPTY_BIT] = notEmpty; // RL13 RL16
        statView[STAT_FREE_LSB +: STAT_FIELD_W] = freeCount; // RL12
        statView[STAT_USED_LSB +: STAT_FIELD_W] = level; // RL11
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            regRdata_r <= '0;
        end else if (ce) begin
            if (regRd && hitReg(regAddr, CTRL_OFS)) begin
                regRdata_r <= ctrlView;
            end else if (regRd && hitReg(regAddr, STAT_OFS)) begin
                regRdata_r <= statView;
            end else begin
                regRdata_r <= '0;
            end
        end
    end

    assign regRdata = regRdata_r;

endmodule : blit_control_status_regs
`default_nettype wire

// *** common/blit_pkg.sv ***
// Constants, field layouts and carrier types of the block-transfer control and status registers.
`default_nettype none
package blit_pkg;

    localparam int ADDR_W = 17;
    localparam int CNT_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_AW = 16;

    localparam logic [REG_AW-1:0] BLIT_BASE = 16'h8000;
    localparam logic [REG_AW-1:0] CTRL_OFS = 16'h8000;
    localparam logic [REG_AW-1:0] STAT_OFS = 16'h8004;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SRC_LIN_BIT = 16;
    localparam int CTRL_DST_LIN_BIT = 17;
    localparam int CTRL_COLOR_BIT = 18;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FULL_BIT = 4;
    localparam int STAT_HALF_BIT = 5;
    localparam int STAT_NEMPTY_BIT = 6;
    localparam int STAT_FREE_LSB = 16;
    localparam int STAT_USED_LSB = 24;
    localparam int STAT_FIELD_W = 5;
    localparam logic [DATA_W-1:0] STAT_RESET = 32'h0000_0000;

    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;
    localparam logic [LEVEL_W-1:0] HALF_LEVEL = 5'h07;
    localparam logic [LEVEL_W-1:0] FULL_LEVEL = 5'h0F;
    localparam logic [LEVEL_W-1:0] RESUME_LEVEL = 5'h0E;

    localparam logic [1:0] STEP_8BPP = 2'h1;
    localparam logic [1:0] STEP_16BPP = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] srcStart;
        logic [ADDR_W-1:0] dstStart;
        logic [ADDR_W-1:0] rowOffset;
        logic [CNT_W-1:0] widthPix;
        logic [CNT_W-1:0] heightRows;
        logic readOp;
    } blit_job_s;

    typedef struct packed {
        logic [ADDR_W-1:0] srcAddr;
        logic [ADDR_W-1:0] dstAddr;
        logic toFifo;
    } mem_req_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_PAUSE
    } eng_state_e;

endpackage : blit_pkg
`default_nettype wire

// *** hdl/blit_addr_step.sv ***
// Address pointer that steps by pixel size and moves to the next row linearly or rectangularly.
`timescale 1ns/1ns
`default_nettype none
module blit_addr_step
    import blit_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic load,
    input wire logic [ADDR_W-1:0] startAddr,
    input wire logic advance,
    input wire logic rowEnd,
    input wire logic linear,
    input wire logic [1:0] step,
    input wire logic [ADDR_W-1:0] rowOffset,
    output logic [ADDR_W-1:0] addr
);

    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] rowStart_r;
    logic [ADDR_W-1:0] stepped;
    logic [ADDR_W-1:0] nextRow;

    assign stepped = addr_r + ADDR_W'(step);
    assign nextRow = rowStart_r + rowOffset;
    assign addr = addr_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            addr_r <= '0;
            rowStart_r <= '0;
        end else if (ce) begin
            if (load) begin
                addr_r <= startAddr;
                rowStart_r <= startAddr;
            end else if (advance && rowEnd && linear) begin
                // Linear: the next row continues right after the last pixel.
                addr_r <= stepped;
                rowStart_r <= stepped;
            end else if (advance && rowEnd) begin
                // Rectangular: the next row starts one row offset after this row's start.
                addr_r <= nextRow;
                rowStart_r <= nextRow;
            end else if (advance) begin
                addr_r <= stepped;
            end
        end
    end

endmodule : blit_addr_step
`default_nettype wire

// *** hdl/blit_fifo_level.sv ***
// Occupancy counter and status flags of the block-transfer data FIFO.
`timescale 1ns/1ns
`default_nettype none
module blit_fifo_level
    import blit_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic push,
    input wire logic pop,
    output logic [LEVEL_W-1:0] level,
    output logic [LEVEL_W-1:0] freeCount,
    output logic notEmpty,
    output logic halfFull,
    output logic fullFlag,
    output logic atCapacity
);

    if (DEPTH < 16 || DEPTH > 31) begin : g_depth_check
        $error("FIFO depth must lie between 16 and 31.");
    end

    localparam logic [LEVEL_W-1:0] CAP = LEVEL_W'(DEPTH);

    logic [LEVEL_W-1:0] level_r;
    logic doPush;
    logic doPop;

    assign atCapacity = (level_r == CAP);
    assign doPush = push && !atCapacity;
    assign doPop = pop && (level_r != '0);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            level_r <= '0;
        end else if (ce) begin
            if (doPush && !doPop) begin
                level_r <= level_r + 5'h01;
            end else if (doPop && !doPush) begin
                level_r <= level_r - 5'h01;
            end
        end
    end

    assign level = level_r;
    assign freeCount = CAP - level_r;
    assign notEmpty = (level_r != '0);
    assign halfFull = (level_r >= HALF_LEVEL);
    assign fullFlag = (level_r >= FULL_LEVEL);

endmodule : blit_fifo_level
`default_nettype wire

// *** testbench/blit_mem_model.sv ***
// Display memory side that accepts pixel requests promptly or with stalls.
`timescale 1ns/1ns
`default_nettype none
module blit_mem_model (
    input wire logic clk_sys,
    input wire logic slow,
    output logic memReady
);
    logic tog;
    initial begin
        tog = 1'b0;
        memReady = 1'b0;
    end
    // Slow mode accepts only every other cycle.
    always @(posedge clk_sys) begin
        tog <= ~tog;
        memReady <= slow ? tog : 1'b1;
    end
endmodule : blit_mem_model
`default_nettype wire

// *** testbench/blit_control_status_regs_checker.sv ***
// Concurrent checks on the block-transfer register and pixel ports.
`timescale 1ns/1ns
`default_nettype none
module blit_control_status_regs_checker
    import blit_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire mem_req_s memReq,
    input wire logic memValid,
    input wire logic memReady,
    input wire logic busy,
    input wire logic colorDepth16
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic cw;
    logic sr;
    assign cw = ce && regWr && regAddr == CTRL_OFS;
    assign sr = ce && regRd && regAddr == STAT_OFS;
    ////////////////////////////////////////
    chk_start_busy: assert property (cw && regWdata[0] |=> busy)
        else $error("busy did not rise after start");
    chk_color_sel: assert property (cw |=> colorDepth16 == $past(regWdata[18]))
        else $error("colour select not stored");
    chk_read_idle: assert property (!$past(regRd) |-> regRdata == '0)
        else $error("read data outside read slot");
    chk_busy_stat: assert property (sr |=> regRdata[0] == $past(busy))
        else $error("status busy bit wrong");
    chk_flag_order: assert property (sr |=> (!regRdata[4] || regRdata[5]) && (!regRdata[5] || regRdata[6]))
        else $error("flag combination illegal");
    chk_free_used: assert property (sr |=> {1'b0, regRdata[20:16]} + {1'b0, regRdata[28:24]} == 6'(DEPTH))
        else $error("free plus used not depth");
    chk_unmapped_zero: assert property (ce && regRd && regAddr != CTRL_OFS && regAddr != STAT_OFS |=> regRdata == '0)
        else $error("unmapped read not zero");
    chk_ctrl_unused: assert property (ce && regRd && regAddr == CTRL_OFS |=> regRdata[31:19] == 13'h0 && regRdata[15:0] == 16'h0)
        else $error("control unused bits not zero");
    chk_idle_quiet: assert property (!busy |-> !memValid)
        else $error("request while idle");
    chk_req_hold: assert property (memValid && !memReady |=> $stable(memReq))
        else $error("request changed before accept");
    cov_start: cover property (cw && regWdata[0] ##1 busy);
    cov_accept: cover property (memValid && memReady);
    cov_full: cover property (sr ##1 regRdata[4]);
endmodule : blit_control_status_regs_checker
bind blit_control_status_regs blit_control_status_regs_checker #(.DEPTH(DEPTH)) chk (.clk_sys(clk_sys), .rstn(rstn),
    .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .memReq(memReq), .memValid(memValid), .memReady(memReady), .busy(busy), .colorDepth16(colorDepth16));
`default_nettype wire

// *** testbench/tb_blit_control_status_regs.sv ***
// Self-checking bench for the block-transfer control and status registers.
`timescale 1ns/1ns
`default_nettype none
module tb_blit_control_status_regs;
    import blit_pkg::*;
    logic clk_sys, rstn, ce, regWr, regRd, memValid, memReady, hostPush, hostPop, busy, colorDepth16, slow;
    logic [REG_AW-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata;
    blit_job_s job;
    mem_req_s memReq;
    int bad_count, tests_run, cyc;
    blit_control_status_regs #(.DEPTH(FIFO_DEPTH)) DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .job(job), .memReq(memReq), .memValid(memValid), .memReady(memReady), .hostPush(hostPush),
        .hostPop(hostPop), .busy(busy), .colorDepth16(colorDepth16));
    blit_mem_model mem (.clk_sys(clk_sys), .slow(slow), .memReady(memReady));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        check(nm, e, regRdata);
    endtask : rd
    task automatic pulse(input bit p, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            hostPush <= p;
            hostPop <= !p;
            @(posedge clk_sys);
            hostPush <= 1'b0;
            hostPop <= 1'b0;
        end
    endtask : pulse
    function automatic logic [31:0] st(input int l, input logic b);
        st = {3'h0, 5'(l), 3'h0, 5'(FIFO_DEPTH - l), 9'h0, l > 0, l >= 7, l >= 15, 3'h0, b};
    endfunction : st
    function automatic logic [31:0] pa(input int b, input int i, input int s, input bit lin);
        pa = b + (lin ? i * s : i / 2 * 16 + i % 2 * s);
    endfunction : pa
    task automatic run(input logic rdOp, input logic [31:0] ctl, input int s, input bit lin);
        int k;
        @(posedge clk_sys);
        job <= '{17'h100, 17'h200, 17'h10, 10'd2, 10'd2, rdOp};
        wr(CTRL_OFS, ctl);
        for (int i = 0; i < 4; i++) begin
            k = 0;
            @(negedge clk_sys);
            while (!(memValid && memReady) && k < 200) begin
                k++;
                @(negedge clk_sys);
            end
            check("src", pa(32'h100, i, s, lin), {15'h0, memReq.srcAddr});
            check("dst", pa(32'h200, i, s, lin), {15'h0, memReq.dstAddr});
        end
        @(negedge clk_sys);
        check("busy", 32'h0, {31'h0, busy});
        check("dir", {31'h0, rdOp}, {31'h0, memReq.toFifo});
        $display("transfer test done");
    endtask : run
    task automatic t_regs();
        rd(CTRL_OFS, 32'h0, "ctrl");
        rd(STAT_OFS, st(0, 0), "stat");
        wr(CTRL_OFS, 32'hFFFF_FFFE);
        rd(CTRL_OFS, 32'h0007_0000, "ctrl");
        check("depth", 32'h1, {31'h0, colorDepth16});
        wr(16'h8008, 32'hFFFF_FFFF);
        rd(16'h8008, 32'h0, "gap");
        wr(STAT_OFS, 32'hFFFF_FFFF);
        rd(STAT_OFS, st(0, 0), "stat");
        wr(CTRL_OFS, 32'h0);
        $display("register test done");
    endtask : t_regs
    task automatic t_fifo();
        for (int l = 1; l <= 17; l++) begin
            pulse(1, 1);
            rd(STAT_OFS, st(l > 16 ? 16 : l, 0), "level");
        end
        for (int l = 15; l >= 0; l--) begin
            pulse(0, 1);
            rd(STAT_OFS, st(l, 0), "level");
        end
        $display("fifo test done");
    endtask : t_fifo
    task automatic t_pause();
        int k;
        @(posedge clk_sys);
        job <= '{17'h100, 17'h200, 17'h10, 10'd9, 10'd2, 1'b1};
        wr(CTRL_OFS, 32'h1);
        repeat (60) @(posedge clk_sys);
        rd(STAT_OFS, st(16, 1), "full");
        pulse(0, 2);
        repeat (5) @(posedge clk_sys);
        rd(STAT_OFS, st(14, 1), "held");
        pulse(0, 1);
        k = 0;
        while (busy !== 1'b0 && k < 100) begin
            k++;
            @(negedge clk_sys);
        end
        rd(STAT_OFS, st(15, 0), "resumed");
        $display("pause test done");
    endtask : t_pause
    ////////////////////////////////////////
    initial begin
        {ce, rstn, regWr, regRd, hostPush, hostPop, slow} = 7'b1000000;
        regAddr = '0;
        regWdata = '0;
        job = '0;
        {bad_count, tests_run, cyc} = '0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs();
        t_fifo();
        run(1'b1, 32'h0000_0001, 1, 1'b0);
        rd(STAT_OFS, st(4, 0), "read fill");
        slow <= 1'b1;
        run(1'b0, 32'h0007_0001, 2, 1'b1);
        rd(STAT_OFS, st(0, 0), "write drain");
        slow <= 1'b0;
        t_pause();
        finish_test();
    end
endmodule : tb_blit_control_status_regs
`default_nettype wire
